/* File: verilog/examine_map.svh */
// Register offsets, field positions, opcodes and reset values of the examine port
`ifndef EXAMINE_MAP_SVH
`define EXAMINE_MAP_SVH

`define OFS_CONTROL 8'h00
`define OFS_OUTPUT 8'h04
`define OFS_INJECT 8'h08
`define OFS_STATUS 8'h0C

`define BIT_RUN 15
`define BIT_INJECT 9
`define BIT_STEP 8

`define CONTROL_RESET 16'h8000
`define INJECT_RESET 16'h0000

`define OP_LDPTR_MASK 16'hFF00
`define OP_LDPTR_CODE 16'h1000
`define OP_OUT_MEM 16'h5A94
`define OP_SPX_MASK 16'hFFF0
`define OP_SPX_CODE 16'h6180
`define OP_OUT_BR 16'h6294

`endif

/* File: verilog/examine_pkg.sv */
// Types shared by the examine port files
package examine_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } step_state_e;
    typedef logic [7:0] byte_t;
endpackage : examine_pkg

/* File: verilog/byte_store.sv */
// Flip-flop byte store with one write port and one read index
`timescale 1ns/1ps
module byte_store #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_idx,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= 8'h00;
        end
        else if (wr_en)
        begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem_q[rd_idx];
endmodule : byte_store

/* File: verilog/examine_port.sv */
// Maintenance examine port: halt, inject and single-step over AHB-Lite
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "examine_map.svh"
// Behaviour
// - Writing zero to control word clears run and halts the microprocessor.
// - Injection register word is the next instruction executed in maintenance mode.
// - Control value 1400 octal sets inject and step; injected instruction executes.
// - Injected 010XXX loads its eight-bit immediate into the address pointer.
// - Injected 055224 copies addressed memory byte to output low byte, increments pointer.
// - Injected 0606XX copies scratchpad entry XX into branch holding register.
// - Injected 061224 copies branch holding register into output low byte.
module examine_port
    import examine_pkg::*;
#(
    parameter int MEM_DEPTH = 256,
    parameter int SP_DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic run,
    output logic step_done,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wr_idx,
    input wire logic [7:0] mem_wr_data,
    input wire logic sp_wr_en,
    input wire logic [3:0] sp_wr_idx,
    input wire logic [7:0] sp_wr_data
);
    logic [15:0] host_control_word_q;
    logic [15:0] injected_instruction_word_q;
    logic [15:0] host_output_word_q;
    byte_t memory_address_pointer_q;
    byte_t branch_holding_register_q;
    step_state_e state_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic step_done_q;
    byte_t mem_rd;
    byte_t sp_rd;
    logic [15:0] instr;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic ctrl_wr;
    logic inject_wr;
    logic step_req;
    logic exec_now;
    logic op_ldptr;
    logic op_out_mem;
    logic op_spx;
    logic op_out_br;
    logic [15:0] wdata;

    assign addr_ok = hsel && hready && htrans[1];
    assign wdata = hwdata[15:0];
    assign ctrl_wr = wr_pend_q && (wr_addr_q == `OFS_CONTROL);
    assign inject_wr = wr_pend_q && (wr_addr_q == `OFS_INJECT);
    assign instr = injected_instruction_word_q;
    assign exec_now = (state_q == ST_EXEC);
    // A control word landing this cycle wins over a pending step
    assign step_req = !ctrl_wr && !host_control_word_q[`BIT_RUN]
        && host_control_word_q[`BIT_INJECT] && host_control_word_q[`BIT_STEP];

    byte_store #(.DEPTH(MEM_DEPTH), .AW(8)) u_mem (
        .clock(clock),
        .rst(rst),
        .wr_en(mem_wr_en),
        .wr_idx(mem_wr_idx),
        .wr_data(mem_wr_data),
        .rd_idx(memory_address_pointer_q),
        .rd_data(mem_rd)
    );

    // Scratchpad loaded by the running microprocessor side
    byte_store #(.DEPTH(SP_DEPTH), .AW(4)) u_scratch (
        .clock(clock),
        .rst(rst),
        .wr_en(sp_wr_en),
        .wr_idx(sp_wr_idx),
        .wr_data(sp_wr_data),
        .rd_idx(instr[3:0]),
        .rd_data(sp_rd)
    );

    // Opcode decode of the injected word; anything else runs as a no-op
    always_comb
    begin
        op_ldptr = 1'b0;
        op_out_mem = 1'b0;
        op_spx = 1'b0;
        op_out_br = 1'b0;
        if ((instr & `OP_LDPTR_MASK) == `OP_LDPTR_CODE)
        begin
            op_ldptr = 1'b1;
        end
        else if (instr == `OP_OUT_MEM)
        begin
            op_out_mem = 1'b1;
        end
        else if ((instr & `OP_SPX_MASK) == `OP_SPX_CODE)
        begin
            op_spx = 1'b1;
        end
        else if (instr == `OP_OUT_BR)
        begin
            op_out_br = 1'b1;
        end
    end

    // Zero-wait slave: writes land one cycle after address phase
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok)
            begin
                wr_addr_q <= haddr;
            end
        end
    end

    // Unmapped offsets and bits 31:16 read as zero
    always_comb
    begin
        case (haddr)
            `OFS_CONTROL: rd_mux = {16'h0000, host_control_word_q};
            `OFS_OUTPUT: rd_mux = {16'h0000, host_output_word_q};
            `OFS_INJECT: rd_mux = {16'h0000, injected_instruction_word_q};
            `OFS_STATUS: rd_mux = {24'h000000, memory_address_pointer_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Captured at the address phase: a read too soon after a step sees old data
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (addr_ok && !hwrite)
        begin
            hrdata_q <= rd_mux;
        end
    end

    // Never stalls and never errors, yet still driven from flops
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // Step bit self-clears when the step completes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            host_control_word_q <= `CONTROL_RESET;
        end
        else if (ctrl_wr)
        begin
            host_control_word_q <= wdata;
        end
        else if (exec_now)
        begin
            host_control_word_q[`BIT_STEP] <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            injected_instruction_word_q <= `INJECT_RESET;
        end
        else if (inject_wr)
        begin
            injected_instruction_word_q <= wdata;
        end
    end

    // One instruction per step request, as EXEC clears the step bit
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (step_req)
                    begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    state_q <= ST_DONE;
                end
                ST_DONE:
                begin
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            memory_address_pointer_q <= 8'h00;
        end
        else if (exec_now)
        begin
            if (op_ldptr)
            begin
                memory_address_pointer_q <= instr[7:0];
            end
            else if (op_out_mem)
            begin
                // Wraps from the top byte back to zero
                memory_address_pointer_q <= memory_address_pointer_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            host_output_word_q <= 16'h0000;
        end
        else if (exec_now)
        begin
            if (op_out_mem)
            begin
                host_output_word_q[7:0] <= mem_rd;
            end
            else if (op_out_br)
            begin
                host_output_word_q[7:0] <= branch_holding_register_q;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            branch_holding_register_q <= 8'h00;
        end
        else if (exec_now && op_spx)
        begin
            branch_holding_register_q <= sp_rd;
        end
    end

    // Pulses the cycle after an instruction executes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            step_done_q <= 1'b0;
        end
        else
        begin
            step_done_q <= exec_now;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign run = host_control_word_q[`BIT_RUN];
    assign step_done = step_done_q;
endmodule : examine_port

/* File: bench/examine_port_asserts.sv */
// Port-level checks of the examine port
`timescale 1ns/1ps
`include "examine_map.svh"
module examine_port_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic run,
    input wire logic step_done
);
    logic ctl_wr_q;
    // Control write in its data phase
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ctl_wr_q <= 1'b0;
        else
            ctl_wr_q <= hsel && hready && htrans[1] && hwrite && haddr == `OFS_CONTROL;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    run_clear_a: assert property (ctl_wr_q && !hwdata[15] |=> !run)
        else $error("run still set after zero control write");
    run_hold_a: assert property (!run && !ctl_wr_q |=> !run)
        else $error("run rose without control write");
    step_fire_a: assert property (ctl_wr_q && hwdata[15:8] == 8'h03 |-> ##3 step_done)
        else $error("step request did not execute");
    step_block_a: assert property (ctl_wr_q && (hwdata[15] || !hwdata[8]) |-> ##3 !step_done)
        else $error("step executed without a halted step request");
    step_cause_a: assert property (step_done |-> $past(ctl_wr_q, 3))
        else $error("step without a request");
    step_pulse_a: assert property (step_done |=> !step_done)
        else $error("more than one instruction per step");
    step_halt_a: assert property (step_done |-> !run)
        else $error("not halted after step");
endmodule : examine_port_asserts
bind examine_port examine_port_asserts u_chk (.clock, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .run, .step_done);

/* File: bench/host_bus.sv */
// Host processor model: single-word AHB-Lite master
`timescale 1ns/1ps
module host_bus (
    input wire logic clock,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hready
);
    assign hready = hreadyout;
    initial
    begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
        // Released data bus must not keep its last value
        hwdata <= ~hwdata;
    endtask : xfer
endmodule : host_bus

/* File: bench/microprocessor_examine_step_port_test.sv */
// Self-checking bench of the examine port against a behavioural model
`timescale 1ns/1ps
`include "examine_map.svh"
module microprocessor_examine_step_port_test;
    logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, run, step_done, mem_wr_en, sp_wr_en;
    logic [7:0] haddr, mem_wr_idx, mem_wr_data, sp_wr_data;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [3:0] sp_wr_idx;
    logic [7:0] mem_m [256];
    logic [7:0] sp_m [16];
    int errors = 0, checks = 0, cyc = 0;
    examine_port i_dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .run, .step_done, .mem_wr_en, .mem_wr_idx, .mem_wr_data,
        .sp_wr_en, .sp_wr_idx, .sp_wr_data);
    host_bus host (.clock, .hrdata, .hreadyout, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready);
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            report_and_stop;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, d, r);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd_chk
    // Output and pointer settle only after the step pulse
    task step_wait;
        wr(`OFS_CONTROL, 32'h0300);
        do @(posedge clock); while (step_done !== 1'b1);
    endtask : step_wait
    initial
    begin
        int i;
        logic [7:0] v, ptr;
        rst = 1'b1;
        {mem_wr_en, sp_wr_en, mem_wr_idx, mem_wr_data, sp_wr_idx, sp_wr_data} = '0;
        i = $urandom(98938);
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd_chk(`OFS_CONTROL, `CONTROL_RESET);
        rd_chk(`OFS_INJECT, `INJECT_RESET);
        for (i = 0; i < 272; i++)
        begin
            @(posedge clock);
            v = $urandom;
            mem_wr_en <= i < 256;
            sp_wr_en <= i >= 256;
            mem_wr_idx <= i[7:0];
            sp_wr_idx <= i[3:0];
            mem_wr_data <= v;
            sp_wr_data <= v;
            if (i < 256)
                mem_m[i] = v;
            else
                sp_m[i - 256] = v;
        end
        @(posedge clock);
        sp_wr_en <= 1'b0;
        wr(`OFS_CONTROL, 32'h0);
        #1 chk({31'h0, run}, 32'h0);
        // Start near the top so the pointer wraps
        ptr = 8'hFE;
        wr(`OFS_INJECT, `OP_LDPTR_CODE | ptr);
        step_wait;
        rd_chk(`OFS_STATUS, ptr);
        wr(`OFS_INJECT, `OP_OUT_MEM);
        repeat (3)
        begin
            step_wait;
            rd_chk(`OFS_OUTPUT, mem_m[ptr]);
            ptr = ptr + 8'h01;
            rd_chk(`OFS_STATUS, ptr);
        end
        rd_chk(`OFS_CONTROL, 32'h0200);
        for (i = 0; i < 16; i++)
        begin
            wr(`OFS_INJECT, `OP_SPX_CODE | i[3:0]);
            step_wait;
            wr(`OFS_INJECT, `OP_OUT_BR);
            step_wait;
            rd_chk(`OFS_OUTPUT, sp_m[i]);
        end
        wr(8'h10, 32'hFFFF);
        rd_chk(8'h10, 32'h0);
        // A pointer load that must not run while the run bit is set
        wr(`OFS_INJECT, `OP_LDPTR_CODE | {8'h00, ~ptr});
        wr(`OFS_CONTROL, 32'h8300);
        repeat (4) @(posedge clock);
        rd_chk(`OFS_STATUS, ptr);
        rd_chk(`OFS_OUTPUT, sp_m[15]);
        rd_chk(`OFS_CONTROL, 32'h8300);
        report_and_stop;
    end
endmodule : microprocessor_examine_step_port_test
